// [hw/asq_pkg.sv]
// Constants, types and helpers shared by the sample sequencer control block
package asq_pkg;
  localparam int NSEQ = 4;
  localparam int MAXD = 8;
  localparam int RES_W = 10;
  localparam int ACC_W = 16;
  localparam int NPERIPH = 4;

  localparam logic [11:0] A_ACTIVE = 12'h000;
  localparam logic [11:0] A_RAW = 12'h004;
  localparam logic [11:0] A_MASK = 12'h008;
  localparam logic [11:0] A_ISC = 12'h00c;
  localparam logic [11:0] A_OVF = 12'h010;
  localparam logic [11:0] A_TRIG = 12'h014;
  localparam logic [11:0] A_UNF = 12'h018;
  localparam logic [11:0] A_PRI = 12'h020;
  localparam logic [11:0] A_KICK = 12'h028;
  localparam logic [11:0] A_MEAN = 12'h030;
  localparam logic [11:0] A_LOOP = 12'h100;
  localparam logic [2:0] SEQ_BLK_LO = 3'h2;
  localparam logic [2:0] SEQ_BLK_HI = 3'h5;
  localparam logic [2:0] SR_SRC = 3'h0;
  localparam logic [2:0] SR_CTL = 3'h1;
  localparam logic [2:0] SR_FIFO = 3'h2;
  localparam logic [2:0] SR_STAT = 3'h3;

  localparam logic [15:0] PRI_RESET = 16'h3210;
  localparam logic [31:0] CTL3_RESET = 32'h0000_0002;
  localparam int CTL_DIFF = 0;
  localparam int CTL_END = 1;
  localparam int CTL_IE = 2;
  localparam int CTL_TS = 3;
  localparam logic [3:0] TRIG_PROC = 4'h0;
  localparam logic [3:0] TRIG_ALWAYS = 4'hf;
  localparam int STAT_TAIL = 0;
  localparam int STAT_HEAD = 4;
  localparam int STAT_EMPTY = 8;
  localparam int STAT_FULL = 12;
  localparam logic [2:0] MEAN_MAX = 3'h6;

  // Control logic target rate; this build runs it on REF_CLK
  localparam real ADC_CLK_TARGET_MHZ = 16.667;
  localparam real REF_CLK_MHZ = 50.0;

  typedef enum {ST_IDLE, ST_ISSUE, ST_WAIT} asq_state_t;

  typedef struct packed {
    logic start;
    logic temp;
    logic diff;
    logic [3:0] chan;
  } asq_conv_t;

  function automatic logic [3:0] seq_depth(input logic [1:0] s);
    case (s)
      2'h0: seq_depth = 4'h8;
      2'h1: seq_depth = 4'h4;
      2'h2: seq_depth = 4'h4;
      default: seq_depth = 4'h1;
    endcase
  endfunction

  function automatic logic [31:0] seq_mask(input logic [1:0] s);
    case (s)
      2'h0: seq_mask = 32'hffff_ffff;
      2'h1: seq_mask = 32'h0000_ffff;
      2'h2: seq_mask = 32'h0000_ffff;
      default: seq_mask = 32'h0000_000f;
    endcase
  endfunction
endpackage

// [hw/asq_top.sv]
// Sample sequencer control: bus slave, triggers, arbitration, averager, FIFOs
//
// Added by the designer: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
module asq_top
  import asq_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [11:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic [NPERIPH-1:0] PERIPH_TRIG,
  input wire logic CONV_DONE,
  input wire logic [RES_W-1:0] CONV_DATA,
  output asq_conv_t CONV_CMD,
  output logic [NSEQ-1:0] IRQ
);

  // Assertions share the block clock and stay quiet while reset is held
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  // Arbitration: lowest-numbered pending sequencer at the lowest priority level
  function automatic logic [2:0] pick(input logic [3:0] pend, input logic [15:0] pri);
    logic [2:0] r;
    r = 3'h0;
    for (int lvl = 3; lvl >= 0; lvl--) begin
      for (int s = 3; s >= 0; s--) begin
        if (pend[s] && pri[4*s +: 2] == 2'(lvl)) begin
          r = {1'b1, 2'(s)};
        end
      end
    end
    pick = r;
  endfunction

  function automatic logic [31:0] bytewr(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    bytewr = (old & ~m) | (d & m);
  endfunction

  logic ack_q;
  logic [31:0] dat_q;
  logic [3:0] en_q;
  logic [3:0] raw_q;
  logic [3:0] im_q;
  logic [3:0] ovf_q;
  logic [3:0] unf_q;
  logic [15:0] emux_q;
  logic [15:0] pri_q;
  logic [2:0] sac_q;
  logic tmlb_q;
  logic [3:0] pend_q;
  logic [3:0] irq_q;
  asq_state_t state_q;
  logic [1:0] cur_q;
  logic [2:0] step_q;
  logic [ACC_W-1:0] acc_q;
  logic [6:0] nacc_q;
  asq_conv_t conv_q;

  wire wb_req = WB_CYC_I & WB_STB_I & ~ack_q;
  wire wr = wb_req & WB_WE_I;
  wire rd = wb_req & ~WB_WE_I;
  wire [2:0] blk = WB_ADR_I[7:5];
  wire is_seq = (WB_ADR_I[11:8] == 4'h0) && (blk >= SEQ_BLK_LO) && (blk <= SEQ_BLK_HI);
  wire [1:0] sidx = 2'(blk - SEQ_BLK_LO);
  wire [2:0] sreg = WB_ADR_I[4:2];
  wire [31:0] wdat = bytewr(32'h0, WB_DAT_I, WB_SEL_I);
  wire wr_act = wr && WB_ADR_I == A_ACTIVE;
  wire wr_mask = wr && WB_ADR_I == A_MASK;
  wire wr_trig = wr && WB_ADR_I == A_TRIG;
  wire wr_pri = wr && WB_ADR_I == A_PRI;
  wire wr_mean = wr && WB_ADR_I == A_MEAN;
  wire wr_loop = wr && WB_ADR_I == A_LOOP;
  wire [3:0] isc_clr = (wr && WB_ADR_I == A_ISC) ? wdat[3:0] : 4'h0;
  wire [3:0] ovf_clr = (wr && WB_ADR_I == A_OVF) ? wdat[3:0] : 4'h0;
  wire [3:0] unf_clr = (wr && WB_ADR_I == A_UNF) ? wdat[3:0] : 4'h0;
  wire [3:0] kick = (wr && WB_ADR_I == A_KICK) ? wdat[3:0] : 4'h0;

  logic [3:0] hit;
  logic [3:0] full;
  logic [3:0] empty;
  logic [3:0] pop_w;
  logic [31:0] src_r [NSEQ];
  logic [31:0] ctl_r [NSEQ];
  logic [31:0] stat_r [NSEQ];
  logic [RES_W-1:0] head_r [NSEQ];

  // Current step fields
  wire [3:0] cur_src = src_r[cur_q][4*step_q +: 4];
  wire [3:0] cur_ctl = ctl_r[cur_q][4*step_q +: 4];
  wire [2:0] win = pick(pend_q, pri_q);
  wire conv_fin = (state_q == ST_WAIT) && (tmlb_q || CONV_DONE);
  // Loopback tags the word with sequencer, step and input so software can check order
  wire [RES_W-1:0] lb_data = {1'b0, cur_q, step_q, cur_src};
  wire [RES_W-1:0] sample = tmlb_q ? lb_data : CONV_DATA;
  wire [ACC_W-1:0] sum = acc_q + ACC_W'(sample);
  wire [6:0] avg_n = 7'h01 << sac_q;
  wire avg_last = nacc_q == 7'(avg_n - 7'h01);
  wire [RES_W-1:0] mean = RES_W'(sum >> sac_q);
  wire push_w = conv_fin && avg_last;
  wire step_last = cur_ctl[CTL_END] || ({1'b0, step_q} == 4'(seq_depth(cur_q) - 4'h1));
  wire [3:0] cur_dec = 4'h1 << cur_q;
  wire [3:0] accept = (state_q == ST_IDLE && win[2]) ? 4'h1 << win[1:0] : 4'h0;
  wire [3:0] push_ok = push_w ? (cur_dec & ~full) : 4'h0;
  wire [3:0] ovf_set = push_w ? (cur_dec & full) : 4'h0;
  wire [3:0] unf_set = pop_w & empty;
  wire [3:0] raw_set = (push_w && cur_ctl[CTL_IE]) ? cur_dec : 4'h0;

  genvar g;
  generate
    for (g = 0; g < NSEQ; g++) begin : g_seq
      logic [31:0] src_q;
      logic [31:0] ctl_q;
      logic [2:0] wp_q;
      logic [2:0] rp_q;
      logic [3:0] cnt_q;
      logic [RES_W-1:0] mem_q [MAXD];
      wire [3:0] code = emux_q[4*g +: 4];
      wire sel_s = is_seq && sidx == 2'(g);
      wire [3:0] dep = seq_depth(2'(g));
      wire [2:0] wp_nx = ({1'b0, wp_q} == 4'(dep - 4'h1)) ? 3'h0 : 3'(wp_q + 3'h1);
      wire [2:0] rp_nx = ({1'b0, rp_q} == 4'(dep - 4'h1)) ? 3'h0 : 3'(rp_q + 3'h1);
      wire pop_ok = pop_w[g] & ~empty[g];
      assign pop_w[g] = rd && sel_s && sreg == SR_FIFO;
      assign hit[g] = (code == TRIG_PROC && kick[g]) || (code == TRIG_ALWAYS) ||
                      (code >= 4'h1 && code <= 4'(NPERIPH) && PERIPH_TRIG[2'(code - 4'h1)]);
      assign full[g] = cnt_q == dep;
      assign empty[g] = cnt_q == 4'h0;
      assign src_r[g] = src_q;
      assign ctl_r[g] = ctl_q;
      assign head_r[g] = mem_q[rp_q];
      assign stat_r[g] = 32'(full[g]) << STAT_FULL | 32'(empty[g]) << STAT_EMPTY |
                         32'(rp_q) << STAT_HEAD | 32'(wp_q) << STAT_TAIL;
      always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
          src_q <= 32'h0;
          ctl_q <= (g == NSEQ - 1) ? CTL3_RESET : 32'h0;
        end else if (wr && sel_s && sreg == SR_SRC) begin
          src_q <= bytewr(src_q, WB_DAT_I, WB_SEL_I) & seq_mask(2'(g));
        end else if (wr && sel_s && sreg == SR_CTL) begin
          ctl_q <= bytewr(ctl_q, WB_DAT_I, WB_SEL_I) & seq_mask(2'(g));
        end
      end
      always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
          wp_q <= 3'h0;
          rp_q <= 3'h0;
          cnt_q <= 4'h0;
        end else begin
          wp_q <= push_ok[g] ? wp_nx : wp_q;
          rp_q <= pop_ok ? rp_nx : rp_q;
          cnt_q <= 4'(cnt_q + 4'(push_ok[g]) - 4'(pop_ok));
        end
      end
      always_ff @(posedge REF_CLK) begin
        if (push_ok[g]) begin
          mem_q[wp_q] <= mean;
        end
      end
      AST_FIFO_BOUND: assert property (cnt_q <= dep)
        else $error("FIFO count beyond depth");
    end
  endgenerate

  // Read mux; unmapped addresses read zero
  logic [31:0] rd_data;
  always_comb begin
    rd_data = 32'h0;
    if (is_seq) begin
      case (sreg)
        SR_SRC: rd_data = src_r[sidx];
        SR_CTL: rd_data = ctl_r[sidx];
        SR_FIFO: rd_data = 32'(head_r[sidx]);
        SR_STAT: rd_data = stat_r[sidx];
        default: rd_data = 32'h0;
      endcase
    end else begin
      case (WB_ADR_I)
        A_ACTIVE: rd_data = 32'(en_q);
        A_RAW: rd_data = 32'(raw_q);
        A_MASK: rd_data = 32'(im_q);
        A_ISC: rd_data = 32'(raw_q & im_q);
        A_OVF: rd_data = 32'(ovf_q);
        A_TRIG: rd_data = 32'(emux_q);
        A_UNF: rd_data = 32'(unf_q);
        A_PRI: rd_data = 32'(pri_q & 16'h3333);
        A_MEAN: rd_data = 32'(sac_q);
        A_LOOP: rd_data = 32'(tmlb_q);
        default: rd_data = 32'h0;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= wb_req;
      dat_q <= rd ? rd_data : 32'h0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      en_q <= 4'h0;
      im_q <= 4'h0;
      emux_q <= 16'h0;
      pri_q <= PRI_RESET;
      sac_q <= 3'h0;
      tmlb_q <= 1'b0;
    end else begin
      en_q <= wr_act ? wdat[3:0] : en_q;
      im_q <= wr_mask ? wdat[3:0] : im_q;
      emux_q <= wr_trig ? wdat[15:0] : emux_q;
      pri_q <= wr_pri ? (wdat[15:0] & 16'h3333) : pri_q;
      sac_q <= wr_mean ? ((wdat[2:0] > MEAN_MAX) ? MEAN_MAX : wdat[2:0]) : sac_q;
      tmlb_q <= wr_loop ? wdat[0] : tmlb_q;
    end
  end

  // Hardware set beats a same-cycle software clear
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      raw_q <= 4'h0;
      ovf_q <= 4'h0;
      unf_q <= 4'h0;
      pend_q <= 4'h0;
      irq_q <= 4'h0;
    end else begin
      raw_q <= (raw_q & ~isc_clr) | raw_set;
      ovf_q <= (ovf_q & ~ovf_clr) | ovf_set;
      unf_q <= (unf_q & ~unf_clr) | unf_set;
      pend_q <= ((pend_q & ~accept) | hit) & en_q;
      irq_q <= raw_q & im_q;
    end
  end

  // Sequencing engine; runs on the single block clock
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      state_q <= ST_IDLE;
      cur_q <= 2'h0;
      step_q <= 3'h0;
      acc_q <= '0;
      nacc_q <= 7'h0;
      conv_q <= '0;
    end else begin
      conv_q.start <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (win[2]) begin
            cur_q <= win[1:0];
            step_q <= 3'h0;
            acc_q <= '0;
            nacc_q <= 7'h0;
            state_q <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          conv_q.start <= ~tmlb_q;
          conv_q.chan <= cur_src;
          conv_q.diff <= cur_ctl[CTL_DIFF];
          conv_q.temp <= cur_ctl[CTL_TS];
          state_q <= ST_WAIT;
        end
        ST_WAIT: begin
          if (conv_fin && !avg_last) begin
            acc_q <= sum;
            nacc_q <= 7'(nacc_q + 7'h1);
            state_q <= ST_ISSUE;
          end else if (push_w) begin
            acc_q <= '0;
            nacc_q <= 7'h0;
            step_q <= 3'(step_q + 3'h1);
            state_q <= step_last ? ST_IDLE : ST_ISSUE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = dat_q;
  assign CONV_CMD = conv_q;
  assign IRQ = irq_q;

  sequence s_ack_pulse;
    WB_ACK_O ##1 !WB_ACK_O;
  endsequence
  sequence s_start_pulse;
    CONV_CMD.start ##1 !CONV_CMD.start;
  endsequence

  // Reference priority: smallest value among pending sequencers
  logic [1:0] min_pri;
  always_comb begin
    min_pri = 2'h3;
    for (int s = 0; s < NSEQ; s++) begin
      if (pend_q[s] && pri_q[4*s +: 2] < min_pri) begin
        min_pri = pri_q[4*s +: 2];
      end
    end
  end

  AST_BUS_ACK: assert property (wb_req |=> s_ack_pulse)
    else $error("Bus request not acknowledged as a single pulse");
  AST_IRQ_GATED: assert property ((raw_q & ~im_q) != 4'h0 && (raw_q & im_q) == 4'h0 |=> IRQ == 4'h0)
    else $error("Interrupt raised for a masked-out sequencer");
  AST_STEP_IRQ: assert property (push_w && cur_ctl[CTL_IE] |=> raw_q[$past(cur_q)])
    else $error("Raw interrupt missing after flagged step");
  AST_OVF_FLAG: assert property (push_w && full[cur_q] |=> ovf_q[$past(cur_q)])
    else $error("Overflow not flagged on full FIFO");
  AST_UNF_FLAG: assert property (unf_set != 4'h0 |=> (unf_q & $past(unf_set)) == $past(unf_set))
    else $error("Underflow not flagged on empty read");
  AST_PRIO_WIN: assert property (state_q == ST_IDLE && pend_q != 4'h0 |=>
      pri_q[4*cur_q +: 2] == $past(min_pri) && step_q == 3'h0 && state_q == ST_ISSUE)
    else $error("Wrong sequencer or step chosen at arbitration");
  AST_NO_DISABLED: assert property (1'b1 |=> (pend_q & ~$past(en_q)) == 4'h0)
    else $error("Trigger pending for disabled sequencer");
  AST_LAST_STOP: assert property (push_w && cur_ctl[CTL_END] |=> state_q == ST_IDLE)
    else $error("Sequence ran past its last step");
  AST_CONV_START: assert property (state_q == ST_ISSUE && !tmlb_q |=> s_start_pulse)
    else $error("Conversion start missing or stretched");
  AST_LOOP_QUIET: assert property (tmlb_q && $past(tmlb_q) |-> !CONV_CMD.start)
    else $error("Converter started during loopback");
  AST_IRQ_FOLLOW: assert property (1'b1 |=> IRQ == $past(raw_q & im_q))
    else $error("Interrupt line does not follow masked status");
  AST_ISC_CLEAR: assert property (isc_clr != 4'h0 |=>
      (raw_q & $past(isc_clr & ~raw_set)) == 4'h0)
    else $error("Interrupt clear did not take effect");
  AST_MEAN_CLAMP: assert property (sac_q <= MEAN_MAX)
    else $error("Averaging count beyond its ceiling");

endmodule

// [verification/asq_conv_model.sv]
// Behavioural converter that answers the block's conversion commands
`timescale 1ns/1ps
module asq_conv_model
  import asq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire asq_conv_t cmd,
  input wire logic slow,
  output logic done,
  output logic [RES_W-1:0] data
);
  logic busy_q;
  logic [2:0] wait_q;
  // The result encodes the command so that the bench can tell steps apart
  always @(posedge clk) begin
    done <= 1'b0;
    // Between results the lines toggle, so a stale sample never matches
    data <= ~data;
    if (!rst_n) begin
      busy_q <= 1'b0;
      wait_q <= 3'h0;
      data <= 10'h2a5;
    end else if (cmd.start) begin
      busy_q <= 1'b1;
      wait_q <= slow ? 3'h5 : 3'h0;
    end else if (busy_q) begin
      if (wait_q == 3'h0) begin
        busy_q <= 1'b0;
        done <= 1'b1;
        data <= {cmd.chan, cmd.temp, cmd.diff, 4'h5};
      end else begin
        wait_q <= wait_q - 3'h1;
      end
    end
  end
endmodule

// [verification/asq_top_bench.sv]
// Self-checking bench for the sample sequencer control block
`timescale 1ns/1ps
module asq_top_bench
  import asq_pkg::*;
;
  logic clk, rst_n, cyc, stb, we, ack, done, slow;
  logic [11:0] adr;
  logic [3:0] sel, ptrig, irq;
  logic [31:0] wdat, rdat;
  logic [RES_W-1:0] cdata;
  asq_conv_t cmd;
  int n_errors = 0;
  int n_compared = 0;
  int n_starts = 0;
  int cycles = 0;
  logic [3:0] chans [64];

  asq_top u_asq_top (.REF_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .PERIPH_TRIG(ptrig), .CONV_DONE(done), .CONV_DATA(cdata),
    .CONV_CMD(cmd), .IRQ(irq));
  asq_conv_model u_asq_conv_model (.clk(clk), .rst_n(rst_n), .cmd(cmd), .slow(slow),
    .done(done), .data(cdata));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task summarize();
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Log every conversion start; a hang is cut short well past the expected run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cmd.start === 1'b1) begin
      chans[n_starts % 64] <= cmd.chan;
      n_starts <= n_starts + 1;
    end
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      summarize();
    end
  end

  task chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // Classic single cycle: hold until ack is sampled, then idle one cycle
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  // Partial byte lanes; lanes return to all-on once the cycle is over
  task wrs(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    sel <= s;
    bus(1'b1, a, d, q);
    sel <= 4'hf;
  endtask

  task rm(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask

  task rc(input logic [11:0] a, input logic [31:0] e);
    rm(a, 32'hffff_ffff, e);
  endtask

  // Fixed settle time covers the slowest sequence used here
  task go(input logic [31:0] k);
    wr(A_KICK, k);
    repeat (100) @(posedge clk);
  endtask

  initial begin
    int n0;
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 12'h000;
    sel = 4'hf;
    wdat = 32'h0;
    ptrig = 4'h0;
    slow = 1'b1;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rc(A_ACTIVE, 32'h0);
    rc(A_PRI, 32'h3210);
    rc(A_MEAN, 32'h0);
    rc(12'h0a4, 32'h2);
    rc(12'h04c, 32'h100);
    rc(12'h0fc, 32'h0);
    // Five steps, input 2 twice, last flag on step 4, steps 5..7 must be skipped
    wr(12'h040, 32'h7653_2210);
    wr(12'h044, 32'h0006_8140);
    wr(A_MASK, 32'h1);
    wr(A_ACTIVE, 32'h1);
    n0 = n_starts;
    go(32'h1);
    chk(32'(n_starts - n0), 32'h5);
    rc(A_RAW, 32'h1);
    rc(A_ISC, 32'h1);
    chk({28'h0, irq}, 32'h1);
    rc(12'h04c, 32'h005);
    rc(12'h048, 32'h005);
    rc(12'h048, 32'h045);
    rc(12'h048, 32'h095);
    rc(12'h048, 32'h0a5);
    rc(12'h048, 32'h0c5);
    rc(12'h04c, 32'h155);
    rm(12'h048, 32'h0, 32'h0);
    rc(A_UNF, 32'h1);
    wr(A_UNF, 32'h1);
    rc(A_UNF, 32'h0);
    wr(A_ISC, 32'h0);
    rc(A_RAW, 32'h1);
    wr(A_ISC, 32'h1);
    rc(A_RAW, 32'h0);
    // Disabled sequencer ignores its kick
    n0 = n_starts;
    go(32'h2);
    chk(32'(n_starts - n0), 32'h0);
    rc(A_RAW, 32'h0);
    // One-entry sequencer run twice overflows; its interrupt is masked off
    wr(12'h0a0, 32'h3);
    wr(12'h0a4, 32'h6);
    wr(A_ACTIVE, 32'h8);
    go(32'h8);
    go(32'h8);
    rm(12'h0ac, 32'h1100, 32'h1000);
    rm(A_OVF, 32'h8, 32'h8);
    rm(A_RAW, 32'h8, 32'h8);
    chk({28'h0, irq}, 32'h0);
    rc(12'h0a8, 32'h0c5);
    wr(A_OVF, 32'h8);
    rm(A_OVF, 32'h8, 32'h0);
    // Averaging: count clamps at 64, four conversions make one entry
    wr(A_MEAN, 32'h7);
    rc(A_MEAN, 32'h6);
    wr(A_MEAN, 32'h2);
    slow <= 1'b0;
    n0 = n_starts;
    go(32'h8);
    chk(32'(n_starts - n0), 32'h4);
    rc(12'h0a8, 32'h0c5);
    wr(A_MEAN, 32'h0);
    // Every peripheral code, one pulse each
    for (int i = 1; i <= 4; i++) begin
      wr(A_TRIG, {16'h0, 4'(i), 12'h0});
      n0 = n_starts;
      ptrig <= 4'(1 << (i - 1));
      @(posedge clk);
      ptrig <= 4'h0;
      repeat (100) @(posedge clk);
      chk(32'(n_starts - n0), 32'h1);
      rc(12'h0a8, 32'h0c5);
    end
    // Always trigger keeps restarting until the sequencer is disabled
    n0 = n_starts;
    wr(A_TRIG, 32'h0000_f000);
    repeat (30) @(posedge clk);
    wr(A_ACTIVE, 32'h0);
    chk(32'(n_starts - n0 > 2), 32'h1);
    wr(A_TRIG, 32'h0);
    repeat (20) @(posedge clk);
    rm(12'h0a8, 32'h0, 32'h0);
    wr(A_OVF, 32'h8);
    // Sequencer 2 given the top priority wins a simultaneous kick
    wr(12'h060, 32'h1);
    wr(12'h064, 32'h2);
    wr(12'h080, 32'h2);
    wr(12'h084, 32'h2);
    wr(A_PRI, 32'h3012);
    wr(A_ACTIVE, 32'h6);
    n0 = n_starts;
    go(32'h6);
    chk(chans[n0 % 64], 32'h2);
    chk(chans[(n0 + 1) % 64], 32'h1);
    // Byte lanes: only lane 1 lands, the unused upper half stays zero
    wrs(12'h060, 32'hffff_5500, 4'ha);
    rc(12'h060, 32'h0000_5501);
    // Loopback: a result without any converter start
    wr(A_LOOP, 32'h1);
    wr(A_ACTIVE, 32'h8);
    rm(12'h0a8, 32'h0, 32'h0);
    wr(A_UNF, 32'h8);
    n0 = n_starts;
    go(32'h8);
    chk(32'(n_starts - n0), 32'h0);
    rc(12'h0a8, 32'h183);
    // Reset after a finished run with a filled FIFO and changed settings
    go(32'h8);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rc(A_PRI, 32'h3210);
    rc(A_LOOP, 32'h0);
    rc(A_ACTIVE, 32'h0);
    rc(12'h0ac, 32'h100);
    summarize();
  end
endmodule
